// [core/ifd_pkg.sv]
// Package of constants for the interrupt flag and dispatch block
package ifd_pkg;
    // Source bit positions, matching the request/enable register layout
    localparam int unsigned PIN0_BIT = 0;
    localparam int unsigned PIN1_BIT = 1;
    localparam int unsigned TMR0_BIT = 5;
    localparam int unsigned TMR1_BIT = 6;
    localparam int unsigned CONV_BIT = 7;
    localparam logic [7:0] SRC_MASK = 8'he3;
    // Reset values
    localparam logic [7:0] FLAG_RST = 8'h00;
    localparam logic [7:0] EN_RST = 8'h00;
    localparam logic [1:0] EDGE_RST = 2'h2;
    localparam logic [1:0] PIN_RST = 2'h3;
    localparam logic [9:0] PUSH_RST = 10'h000;
    // Edge select encodings for pin 0
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Interrupt entry address and program counter width
    localparam int unsigned PC_W = 10;
    localparam logic [9:0] VECTOR_ADDR = 10'h008;
    // Dispatch states
    typedef enum logic [0:0] {
        IFD_IDLE,
        IFD_TAKEN
    } ifd_state_t;
endpackage : ifd_pkg

// [core/ifd_irq_flag_dispatch.sv]
// Interrupt request flags and single-vector dispatch for five sources
//
// Contract
// [R1] Timer 0 overflow sets its request flag whatever its enable says.
// [R2] Timer 0 enable and flag both set cause a branch to the vector.
// [R3] Timer 0 disabled: flag still sets, no branch.
// [R4] Timer 1 overflow sets its request flag whatever its enable says.
// [R5] Timer 1 vectors only when its enable and flag are both set.
// [R6] Timer 1 disabled: flag still sets, no branch.
// [R7] Conversion done sets the converter flag regardless of its enable.
// [R8] Converter enable and flag both set cause a branch to the vector.
// [R9] Converter disabled: flag still sets, no branch.
// [R10] Pin 0 flag sets on the edge picked by its edge select.
// [R11] Pin 1 flag sets on falling edges only.
// [R12] Handler tests enable and flag of each source to pick a service.
// [R13] Firmware orders simultaneous sources; hardware has one vector.
// [R14] Flags hold until firmware writes zero to clear them.
// [R15] Nothing is taken unless the global enable is set.
// [R16] Taking an interrupt loads PC with 8 and pushes the return address.
// [R17] Simultaneous events each set their own flag, none lost.
`timescale 1ns/1ps
`default_nettype none
module ifd_irq_flag_dispatch (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_timer0_ovf,
    input wire logic i_timer1_ovf,
    input wire logic i_conv_done,
    input wire logic i_ext_pin0,
    input wire logic i_ext_pin1,
    input wire logic [1:0] i_pin0_edge_select,
    input wire logic i_global_irq_enable,
    input wire logic [7:0] i_irq_enable,
    input wire logic [7:0] i_flag_clear_n,
    input wire logic i_can_take,
    input wire logic [9:0] i_return_pc,
    input wire logic i_reti,
    output logic [7:0] o_request_flags,
    output logic o_irq_pending,
    output logic o_vector_take,
    output logic [9:0] o_vector_pc,
    output logic o_stack_push,
    output logic [9:0] o_push_data
);
    // Pin synchronisers; stage one is read only by stage two
    logic [1:0] pin_s1_r;
    logic [1:0] pin_s1_nxt;
    logic [1:0] pin_s2_r;
    logic [1:0] pin_s2_nxt;
    logic [1:0] pin_d_r;
    logic [1:0] pin_d_nxt;
    logic pin0_edge;
    logic pin1_edge;

    // Request flags
    logic [7:0] flag_r;
    logic [7:0] flag_nxt;
    logic [7:0] event_v;

    // Dispatch state
    ifd_pkg::ifd_state_t state_r;
    ifd_pkg::ifd_state_t state_nxt;
    logic any_armed;
    logic pend_r;
    logic pend_nxt;
    logic take_r;
    logic take_nxt;
    logic [9:0] push_r;
    logic [9:0] push_nxt;

    // Vector address register, so the output leaves a flip-flop
    logic [9:0] vpc_r;
    logic [9:0] vpc_nxt;

    // Edge select decode for pin 0
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic prev,
                                      input logic cur);
        case (sel)
            ifd_pkg::EDGE_RISE: edge_hit = !prev && cur;
            ifd_pkg::EDGE_FALL: edge_hit = prev && !cur;
            ifd_pkg::EDGE_BOTH: edge_hit = prev != cur;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // Pin sampling chain, next values
    // The pins are asynchronous, so two stages come before any logic;
    // the third stage only holds the previous settled level for edges.
    always_comb begin
        pin_s1_nxt = {i_ext_pin1, i_ext_pin0};
        pin_s2_nxt = pin_s1_r;
        pin_d_nxt = pin_s2_r;
    end

    // Pin sampling chain registers
    // All stages reset high: a pin resting high at release gives no
    // false falling edge. A pin held low through reset will show one.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pin_s1_r <= ifd_pkg::PIN_RST;
            pin_s2_r <= ifd_pkg::PIN_RST;
            pin_d_r <= ifd_pkg::PIN_RST;
        end else begin
            pin_s1_r <= pin_s1_nxt;
            pin_s2_r <= pin_s2_nxt;
            pin_d_r <= pin_d_nxt;
        end
    end

    // Edge detection on synchronised pins
    // Pin 0 follows its select; pin 1 is wired to falling edges only.
    always_comb begin
        pin0_edge = edge_hit(i_pin0_edge_select, pin_d_r[0],
                             pin_s2_r[0]); // [R10]
        pin1_edge = edge_hit(ifd_pkg::EDGE_FALL, pin_d_r[1],
                             pin_s2_r[1]); // [R11]
    end

    // Flag update: independent per bit, set wins over a clearing write
    // Events ignore the enables, so a disabled source still flags.
    // Losing an event to a late clear would drop a request silently,
    // hence the set term is ORed in after the clear mask.
    always_comb begin
        event_v = 8'h00;
        event_v[ifd_pkg::PIN0_BIT] = pin0_edge;
        event_v[ifd_pkg::PIN1_BIT] = pin1_edge;
        event_v[ifd_pkg::TMR0_BIT] = i_timer0_ovf; // [R1] [R3]
        event_v[ifd_pkg::TMR1_BIT] = i_timer1_ovf; // [R4] [R6]
        event_v[ifd_pkg::CONV_BIT] = i_conv_done; // [R7] [R9]
        flag_nxt = ((flag_r & i_flag_clear_n) | event_v)
                   & ifd_pkg::SRC_MASK; // [R14] [R17]
    end

    // Flag registers; unused bit positions stay at zero
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            flag_r <= ifd_pkg::FLAG_RST;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // Dispatch: one shared vector, no hardware priority
    // Firmware sorts out which source to serve, so the block only says
    // that some armed source is pending. No nesting: once the vector is
    // taken, nothing more is taken until the handler returns.
    always_comb begin
        any_armed = |(flag_r & i_irq_enable & ifd_pkg::SRC_MASK);
        pend_nxt = i_global_irq_enable
                   && any_armed; // [R2] [R5] [R8] [R15]
        take_nxt = 1'b0;
        push_nxt = push_r;
        state_nxt = state_r;
        case (state_r)
            ifd_pkg::IFD_IDLE: begin
                // Global enable is checked again, as pending is a cycle old
                if (pend_r && i_global_irq_enable && i_can_take) begin
                    take_nxt = 1'b1; // [R16]
                    push_nxt = i_return_pc; // [R16]
                    state_nxt = ifd_pkg::IFD_TAKEN;
                end
            end
            ifd_pkg::IFD_TAKEN: begin
                // Return frees the dispatcher for the next cycle
                if (i_reti) begin
                    state_nxt = ifd_pkg::IFD_IDLE;
                end
            end
            default: begin
                state_nxt = ifd_pkg::IFD_IDLE;
            end
        endcase
    end

    // Dispatch registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_r <= ifd_pkg::IFD_IDLE;
            pend_r <= 1'b0;
            take_r <= 1'b0;
            push_r <= ifd_pkg::PUSH_RST;
        end else begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            take_r <= take_nxt;
            push_r <= push_nxt;
        end
    end

    // Vector address; constant, but kept in a flip-flop like the others
    always_comb begin
        vpc_nxt = ifd_pkg::VECTOR_ADDR; // [R16]
    end

    // Vector address register; reset value is the vector itself
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            vpc_r <= ifd_pkg::VECTOR_ADDR;
        end else begin
            vpc_r <= vpc_nxt;
        end
    end

    // Outputs straight from registers
    // Stack push and vector load are the same pulse by design.
    assign o_request_flags = flag_r;
    assign o_irq_pending = pend_r;
    assign o_vector_take = take_r;
    assign o_vector_pc = vpc_r; // [R16]
    assign o_stack_push = take_r;
    assign o_push_data = push_r;
endmodule : ifd_irq_flag_dispatch
`default_nettype wire

// [dv/ifd_monitor.sv]
// Checker for request flags and vector dispatch
`timescale 1ns/1ps
`default_nettype none
module ifd_monitor (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_timer0_ovf,
    input wire logic i_timer1_ovf,
    input wire logic i_conv_done,
    input wire logic i_global_irq_enable,
    input wire logic [7:0] i_irq_enable,
    input wire logic [7:0] o_request_flags,
    input wire logic o_irq_pending,
    input wire logic o_vector_take,
    input wire logic [9:0] o_vector_pc,
    input wire logic o_stack_push
);
    // One domain, so clock and reset are given once
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    property p_t0; i_timer0_ovf |=> o_request_flags[5]; endproperty
    a_t0: assert property (p_t0) else $error("timer0 flag");
    property p_t1; i_timer1_ovf |=> o_request_flags[6]; endproperty
    a_t1: assert property (p_t1) else $error("timer1 flag");
    property p_cv; i_conv_done |=> o_request_flags[7]; endproperty
    a_cv: assert property (p_cv) else $error("conv flag");
    property p_all; i_timer0_ovf && i_timer1_ovf && i_conv_done
        |=> o_request_flags[7:5] == 3'h7 && o_request_flags[4:2] == 3'h0;
    endproperty
    a_all: assert property (p_all) else $error("joint set");
    property p_pend; 1 |=> o_irq_pending == $past(i_global_irq_enable
        && |(o_request_flags & i_irq_enable)); endproperty
    a_pend: assert property (p_pend) else $error("pending");
    property p_gie; o_vector_take
        |-> $past(o_irq_pending && i_global_irq_enable); endproperty
    a_gie: assert property (p_gie) else $error("take cause");
    property p_vec; o_vector_take
        |-> o_stack_push && o_vector_pc == ifd_pkg::VECTOR_ADDR; endproperty
    a_vec: assert property (p_vec) else $error("vector");
    property p_one; o_vector_take |=> !o_vector_take; endproperty
    a_one: assert property (p_one) else $error("take width");
    property p_nogie; !i_global_irq_enable |=> !o_irq_pending;
    endproperty
    a_nogie: assert property (p_nogie) else $error("no enable");
    property p_arm; o_vector_take
        |-> $past(|(o_request_flags & i_irq_enable), 2); endproperty
    a_arm: assert property (p_arm) else $error("unarmed");
endmodule : ifd_monitor
`default_nettype wire

// [dv/ifd_cpu_model.sv]
// Core and handler model: waits, clears one flag, returns
`timescale 1ns/1ps
`default_nettype none
module ifd_cpu_model (
    input wire logic clk,
    input wire logic [7:0] flags,
    input wire logic [7:0] en,
    input wire logic take,
    input wire logic [1:0] lag,
    output logic [7:0] clr_n,
    output logic reti,
    output logic can_take,
    output logic [9:0] ret_pc
);
    // Lowest enabled pending bit wins; the vector is shared by all
    initial begin
        {clr_n, reti, can_take, ret_pc} = {8'hff, 2'h1, 10'h155};
        forever begin
            @(posedge clk iff take);
            repeat (lag) @(posedge clk);
            #1;
            for (int b = 0; b < 8; b++) if (flags[b] && en[b] && &clr_n)
                clr_n[b] = 1'b0;
            @(posedge clk);
            #1 {clr_n, reti, ret_pc} = {8'hff, 1'b1, ret_pc + 10'h001};
            @(posedge clk);
            #1 reti = 1'b0;
        end
    end
endmodule : ifd_cpu_model
`default_nettype wire

// [dv/tb_irq_flag_dispatch.sv]
// Random bench with a mirrored flag model
`timescale 1ns/1ps
`default_nettype none
module tb_irq_flag_dispatch;
    logic clk = 0, rst_n = 0, t0 = 0, t1 = 0, cv = 0, p0 = 1, p1 = 1, global_irq_enable = 0;
    logic [1:0] sel = 2'h0, lag = 2'h0;
    logic [7:0] en = 8'h00, ex = 8'h00, fl, clr_n;
    logic [3:0] h0 = 4'hf, h1 = 4'hf;
    logic take, push, pend, reti, ct, pexp = 0;
    logic [9:0] vpc, pd, rpc;
    logic [15:0] r = 16'h5a95;
    int miscompares = 0, n_checks = 0;
    function logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    // Select bit 0 takes rising, bit 1 falling
    function logic hit(input logic [1:0] s, input logic old, nw);
        return (nw & ~old & s[0]) | (old & ~nw & s[1]);
    endfunction : hit
    task chk(input logic [9:0] got, want);
        n_checks++;
        if (got !== want) begin
            miscompares++;
            $display("FAIL %0t %h %h", $time, got, want);
        end
    endtask : chk
    task tally_and_finish;
        if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    ifd_irq_flag_dispatch dut (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_timer0_ovf(t0), .i_timer1_ovf(t1), .i_conv_done(cv),
        .i_ext_pin0(p0), .i_ext_pin1(p1), .i_pin0_edge_select(sel),
        .i_global_irq_enable(global_irq_enable), .i_irq_enable(en), .i_flag_clear_n(clr_n),
        .i_can_take(ct), .i_return_pc(rpc), .i_reti(reti),
        .o_request_flags(fl), .o_irq_pending(pend), .o_vector_take(take),
        .o_vector_pc(vpc), .o_stack_push(push), .o_push_data(pd));
    ifd_cpu_model cpu (.clk(clk), .flags(fl), .en(en), .take(take),
        .lag(lag), .clr_n(clr_n), .reti(reti), .can_take(ct), .ret_pc(rpc));
    initial forever #2 clk = ~clk;
    // Pins land two edges late; a set beats a clear in the same cycle
    always @(posedge clk) begin
        h0 <= {h0[2:0], p0};
        h1 <= {h1[2:0], p1};
        pexp <= rst_n && global_irq_enable && |(fl & en);
        ex <= !rst_n ? 8'h00 : (ex & clr_n) | {cv, t1, t0, 3'h0,
            hit(2'h2, h1[2], h1[1]), hit(sel, h0[2], h0[1])};
    end
    // Pins move only on multiples of 8, select well clear of them
    initial begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1;
        for (int i = 0; i < 4096; i++) begin
            @(posedge clk);
            #1 chk(fl, ex);
            if (take) chk(pd, rpc);
            chk({9'h000, pend}, {9'h000, pexp});
            chk(vpc, ifd_pkg::VECTOR_ADDR);
            chk({9'h000, push}, {9'h000, take});
            r = lfsr(r);
            {t0, t1, cv} = (i % 512 == 7) ? 3'h7 : r[2:0] & r[5:3];
            if (i % 8 == 0) {p0, p1} = r[7:6];
            if (i % 256 == 4) {sel, en, global_irq_enable, lag} = {sel + 2'h1,
                (i < 512) ? 8'h00 : r[15:8], r[9] | r[12], r[11:10]};
        end
        tally_and_finish;
    end
    // Cut a hang short at about two and a half times the planned run
    initial begin
        #40000 miscompares++;
        tally_and_finish;
    end
endmodule : tb_irq_flag_dispatch
bind ifd_irq_flag_dispatch ifd_monitor mon (.i_ref_clk, .i_rst_n,
    .i_timer0_ovf, .i_timer1_ovf, .i_conv_done, .i_global_irq_enable,
    .i_irq_enable, .o_request_flags, .o_irq_pending, .o_vector_take,
    .o_vector_pc, .o_stack_push);
`default_nettype wire
